// >>> rtl/scs_baud.sv
// smart-card serial channel: bit rate generator, 16x tick
// assumes the external clock pin is synchronous to clk_i
`timescale 1ns/1ps
`default_nettype none
module scs_baud import scs_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ext_sel_i,
  input wire logic [1:0] pre_sel_i,
  input wire logic [7:0] div_i,
  input wire logic ext_clk_i,
  output logic tick_o
);
  typedef struct packed {
    logic [4:0] pre;
    logic ext_q;
    logic [7:0] div;
    logic tick;
  } scs_baud_state_type;

  scs_baud_state_type r_reg;
  scs_baud_state_type r_next;
  logic src;

  ////////////////////////////////////////////////////////////////
  // source pick, then divide by divisor plus one
  always_comb begin
    r_next = r_reg;
    r_next.pre = r_reg.pre + 5'h01;
    r_next.ext_q = ext_clk_i;
    r_next.tick = 1'b0;
    if (ext_sel_i) begin
      src = ext_clk_i & ~r_reg.ext_q;
    end else if (pre_sel_i == PRE_F1) begin
      src = 1'b1;
    end else if (pre_sel_i == PRE_F8) begin
      src = (r_reg.pre[2:0] == PRE8_END[2:0]);
    end else begin
      src = (r_reg.pre == PRE32_END);
    end
    if (src) begin
      if (r_reg.div >= div_i) begin
        r_next.div = 8'h00;
        r_next.tick = 1'b1;
      end else begin
        r_next.div = r_reg.div + 8'h01;
      end
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign tick_o = r_reg.tick;
endmodule
`default_nettype wire

// >>> rtl/scs_channel.sv
// smart-card serial channel: registers, transmitter, receiver
// assumes classic Wishbone master and one shared pulled-up line
`timescale 1ns/1ps
`default_nettype none
// Contract
// - channel runs only with the mode field set to eight data bits.
// - each frame has exactly one stop bit; stop length bit clear.
// - direct convention: even parity, no inversion, LSB first.
// - inverse convention: odd parity, inverted data, MSB first.
// - internal rate is f1, f8 or f32 over 16 times divisor plus one.
// - external clock pin over 16 times divisor plus one when selected.
// - no sleep function gating reception on the received MSB.
// - cause bit selects transmit interrupt on completion, not buffer empty.
// - transmit starts only with enable set and buffer holding data.
// - reception starts only with enable set and a start bit seen.
// - receive request when a character moves into the receive buffer.
// - transmit request when the shift out has fully completed.
// - overrun overwrites the buffer and raises no receive request.
// - parity error with signalling enabled drives the output pin low.
// - signalling enabled delays transmit completion to error detect point.
// - card reports error low; line level sampled at transmit request.
// - direct sends bit 0 first true; inverse bit 7 first inverted.
// - shared pins routed by two select bits and two-wire valid bit.
// - inversion applies at buffer write and read, not framing bits.
// - error sum set on overrun, framing or parity error.
// - framing error when stop bit is not found where expected.
// - output pin idles high, or floats when open drain chosen.
module scs_channel import scs_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire scs_wb_req_type wb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic serial_in_pin_i,
  output logic serial_out_pin_o,
  output logic serial_out_pin_oe_n_o,
  input wire logic ext_baud_clock_pin_i,
  output logic port_route_sel_lo_o,
  output logic port_route_sel_hi_o,
  output logic two_wire_unit_valid_o,
  output logic two_wire_owns_o,
  output logic tx_int_o,
  output logic rx_int_o
);
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] ctl0;
    logic [7:0] ctl1;
    logic [7:0] brg;
    logic [7:0] txb;
    logic txb_empty;
    logic [7:0] rxb;
    logic rx_full;
    logic [6:0] stat;
    logic [2:0] route;
    logic ack;
    logic [31:0] dat;
    scs_tx_state_type tx_st;
    logic [3:0] tx_cnt;
    logic [2:0] tx_bits;
    logic [7:0] tx_sr;
    logic tx_par;
    logic tx_line;
    scs_rx_state_type rx_st;
    logic [3:0] rx_cnt;
    logic [2:0] rx_bits;
    logic [7:0] rx_sr;
    logic rx_par;
    logic rx_drv;
    logic tx_int;
    logic rx_int;
  } scs_chan_state_type;

  scs_chan_state_type r_reg;
  scs_chan_state_type r_next;
  logic tick;
  logic rx_lvl;
  logic req;
  logic wr;
  logic active;
  logic msb;
  logic even;
  logic pen;
  logic errsig;
  logic tx_done;
  logic perr;

  ////////////////////////////////////////////////////////////////
  // bit rate generator
  scs_baud u_baud (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ext_sel_i(r_reg.mode[M_CKSEL]),
    .pre_sel_i(r_reg.ctl0[C0_PRE_LO+1:C0_PRE_LO]),
    .div_i(r_reg.brg),
    .ext_clk_i(ext_baud_clock_pin_i),
    .tick_o(tick)
  );

  // pin routing; the error pulse pulls the output line low
  scs_route u_route (
    .route_i(r_reg.route),
    .od_i(r_reg.ctl0[C0_OD]),
    .line_i(r_reg.tx_line & ~r_reg.rx_drv),
    .pin_i(serial_in_pin_i),
    .pin_o(serial_out_pin_o),
    .pin_oe_n_o(serial_out_pin_oe_n_o),
    .rx_lvl_o(rx_lvl),
    .two_wire_owns_o(two_wire_owns_o)
  );

  ////////////////////////////////////////////////////////////////
  // configuration decode
  assign active = (r_reg.mode[2:0] == MODE_8BIT)
    & ~r_reg.mode[M_STOP2];
  assign msb = r_reg.ctl0[C0_MSB];
  assign even = r_reg.mode[M_PEVEN];
  assign pen = r_reg.mode[M_PEN];
  assign errsig = r_reg.ctl1[C1_ERRSIG];
  assign req = wb_i.cyc & wb_i.stb & ~r_reg.ack;
  assign wr = req & wb_i.we & wb_i.sel[0];

  ////////////////////////////////////////////////////////////////
  // next state: bus first, hardware events after so a set wins
  always_comb begin
    r_next = r_reg;
    r_next.ack = req;
    r_next.tx_int = 1'b0;
    r_next.rx_int = 1'b0;
    tx_done = 1'b0;
    perr = 1'b0;

    // register read, one-cycle answer
    if (req) begin
      r_next.dat = 32'h0000_0000;
      case (wb_i.adr)
        ADR_MODE: r_next.dat[7:0] = r_reg.mode;
        ADR_CTL0: r_next.dat[7:0] = r_reg.ctl0;
        ADR_CTL1: begin
          r_next.dat[7:0] = r_reg.ctl1;
          r_next.dat[C1_TXEMPTY] = r_reg.txb_empty;
          r_next.dat[C1_RXFULL] = r_reg.rx_full;
        end
        ADR_BRG: r_next.dat[7:0] = r_reg.brg;
        ADR_RXB: begin
          r_next.dat[7:0] = scs_inv(r_reg.rxb, r_reg.ctl1[C1_INV]);
          if (!wb_i.we) begin
            r_next.rx_full = 1'b0;
          end
        end
        ADR_STAT: r_next.dat[6:0] = r_reg.stat;
        ADR_ROUTE: r_next.dat[2:0] = r_reg.route;
        default: r_next.dat = 32'h0000_0000;
      endcase
    end

    // register write, low byte lane
    if (wr) begin
      case (wb_i.adr)
        ADR_MODE: r_next.mode = wb_i.dat[7:0];
        ADR_CTL0: r_next.ctl0 = wb_i.dat[7:0];
        ADR_CTL1: r_next.ctl1 = wb_i.dat[7:0] & C1_WMASK;
        ADR_BRG: r_next.brg = wb_i.dat[7:0];
        ADR_TXB: begin
          r_next.txb = scs_inv(wb_i.dat[7:0], r_reg.ctl1[C1_INV]);
          r_next.txb_empty = 1'b0;
        end
        ADR_STAT: r_next.stat = r_reg.stat & ~wb_i.dat[6:0];
        ADR_ROUTE: r_next.route = wb_i.dat[2:0];
        default: r_next.dat = r_next.dat;
      endcase
    end

    //////////////////////////////////////////////////////////////
    // transmitter
    unique case (r_reg.tx_st)
      TX_IDLE: begin
        r_next.tx_line = 1'b1;
        if (active && r_reg.ctl1[C1_TXEN] && !r_reg.txb_empty) begin
          r_next.tx_sr = r_reg.txb;
          r_next.txb_empty = ~(wr && (wb_i.adr == ADR_TXB)); // same-cycle write stays pending
          r_next.tx_par = scs_par(r_reg.txb, even);
          r_next.tx_cnt = 4'h0;
          r_next.tx_line = 1'b0;
          r_next.tx_st = TX_START;
          if (!r_reg.ctl1[C1_TXCAUSE]) begin
            r_next.stat[S_TXIRQ] = 1'b1;
            r_next.tx_int = 1'b1;
          end
        end
      end
      TX_START: begin
        if (tick) begin
          r_next.tx_cnt = r_reg.tx_cnt + 4'h1;
          if (r_reg.tx_cnt == OS_LAST) begin
            r_next.tx_bits = 3'h0;
            r_next.tx_line = msb ? r_reg.tx_sr[7] : r_reg.tx_sr[0];
            r_next.tx_st = TX_DATA;
          end
        end
      end
      TX_DATA: begin
        if (tick) begin
          r_next.tx_cnt = r_reg.tx_cnt + 4'h1;
          if (r_reg.tx_cnt == OS_LAST) begin
            r_next.tx_bits = r_reg.tx_bits + 3'h1;
            if (msb) begin
              r_next.tx_sr = {r_reg.tx_sr[6:0], 1'b0};
              r_next.tx_line = r_reg.tx_sr[6];
            end else begin
              r_next.tx_sr = {1'b0, r_reg.tx_sr[7:1]};
              r_next.tx_line = r_reg.tx_sr[1];
            end
            if (r_reg.tx_bits == BITS_LAST) begin
              r_next.tx_line = pen ? r_reg.tx_par : 1'b1;
              r_next.tx_st = pen ? TX_PAR : TX_STOP;
            end
          end
        end
      end
      TX_PAR: begin
        if (tick) begin
          r_next.tx_cnt = r_reg.tx_cnt + 4'h1;
          if (r_reg.tx_cnt == OS_LAST) begin
            r_next.tx_line = 1'b1;
            r_next.tx_st = TX_STOP;
          end
        end
      end
      TX_STOP: begin
        if (tick) begin
          r_next.tx_cnt = r_reg.tx_cnt + 4'h1;
          if (r_reg.tx_cnt == OS_LAST) begin
            if (errsig) begin
              r_next.tx_st = TX_GUARD;
            end else begin
              tx_done = 1'b1;
              r_next.tx_st = TX_IDLE;
            end
          end
        end
      end
      TX_GUARD: begin
        // wait half a bit into the card's error window
        if (tick) begin
          r_next.tx_cnt = r_reg.tx_cnt + 4'h1;
          if (r_reg.tx_cnt == OS_MID) begin
            tx_done = 1'b1;
            r_next.tx_cnt = 4'h0;
            r_next.tx_st = TX_IDLE;
          end
        end
      end
    endcase

    // completion: request when the cause bit is set, and sample the card's answer
    if (tx_done) begin
      if (r_reg.ctl1[C1_TXCAUSE]) begin
        r_next.stat[S_TXIRQ] = 1'b1;
        r_next.tx_int = 1'b1;
      end
      if (!rx_lvl) begin
        r_next.stat[S_CARDERR] = 1'b1;
      end
    end

    //////////////////////////////////////////////////////////////
    // receiver; no address or sleep filtering on the MSB
    unique case (r_reg.rx_st)
      RX_IDLE: begin
        if (tick && active && r_reg.ctl1[C1_RXEN] && !rx_lvl) begin
          r_next.rx_cnt = 4'h0;
          r_next.rx_st = RX_START;
        end
      end
      RX_START: begin
        if (tick) begin
          r_next.rx_cnt = r_reg.rx_cnt + 4'h1;
          if (r_reg.rx_cnt == OS_MID) begin
            r_next.rx_cnt = 4'h0;
            r_next.rx_bits = 3'h0;
            r_next.rx_st = rx_lvl ? RX_IDLE : RX_DATA;
          end
        end
      end
      RX_DATA: begin
        if (tick) begin
          r_next.rx_cnt = r_reg.rx_cnt + 4'h1;
          if (r_reg.rx_cnt == OS_LAST) begin
            r_next.rx_bits = r_reg.rx_bits + 3'h1;
            if (msb) begin
              r_next.rx_sr = {r_reg.rx_sr[6:0], rx_lvl};
            end else begin
              r_next.rx_sr = {rx_lvl, r_reg.rx_sr[7:1]};
            end
            if (r_reg.rx_bits == BITS_LAST) begin
              r_next.rx_st = pen ? RX_PAR : RX_STOP;
            end
          end
        end
      end
      RX_PAR: begin
        if (tick) begin
          r_next.rx_cnt = r_reg.rx_cnt + 4'h1;
          if (r_reg.rx_cnt == OS_LAST) begin
            r_next.rx_par = rx_lvl;
            r_next.rx_st = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (tick) begin
          r_next.rx_cnt = r_reg.rx_cnt + 4'h1;
          if (r_reg.rx_cnt == OS_LAST) begin
            perr = pen && (scs_par(r_reg.rx_sr, even) != r_reg.rx_par);
            r_next.rxb = r_reg.rx_sr;
            if (r_reg.rx_full) begin
              r_next.stat[S_OVR] = 1'b1;
            end else begin
              r_next.stat[S_RXIRQ] = 1'b1;
              r_next.rx_int = 1'b1;
            end
            r_next.rx_full = 1'b1;
            if (!rx_lvl) begin
              r_next.stat[S_FER] = 1'b1;
            end
            if (perr) begin
              r_next.stat[S_PER] = 1'b1;
            end
            r_next.rx_cnt = 4'h0;
            r_next.rx_st = (perr && errsig) ? RX_GAP : RX_IDLE;
          end
        end
      end
      RX_GAP: begin
        // let the rest of the stop bit pass, then signal
        if (tick) begin
          r_next.rx_cnt = r_reg.rx_cnt + 4'h1;
          if (r_reg.rx_cnt == OS_MID) begin
            r_next.rx_cnt = 4'h0;
            r_next.rx_drv = 1'b1;
            r_next.rx_st = RX_ERR;
          end
        end
      end
      RX_ERR: begin
        if (tick) begin
          r_next.rx_cnt = r_reg.rx_cnt + 4'h1;
          if (r_reg.rx_cnt == OS_LAST) begin
            r_next.rx_drv = 1'b0;
            r_next.rx_st = RX_IDLE;
          end
        end
      end
    endcase

    // error sum follows the three error flags
    r_next.stat[S_ESUM] = r_next.stat[S_OVR] | r_next.stat[S_FER]
      | r_next.stat[S_PER];
  end

  ////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg <= '0;
      r_reg.mode <= REG_RST;
      r_reg.ctl0 <= REG_RST;
      r_reg.ctl1 <= REG_RST;
      r_reg.brg <= REG_RST;
      r_reg.route <= ROUTE_RST;
      r_reg.txb_empty <= 1'b1;
      r_reg.tx_line <= 1'b1;
      r_reg.tx_st <= TX_IDLE;
      r_reg.rx_st <= RX_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs
  assign wb_dat_o = r_reg.dat;
  assign wb_ack_o = r_reg.ack;
  assign port_route_sel_lo_o = r_reg.route[0];
  assign port_route_sel_hi_o = r_reg.route[1];
  assign two_wire_unit_valid_o = r_reg.route[2];
  assign tx_int_o = r_reg.tx_int;
  assign rx_int_o = r_reg.rx_int;
endmodule
`default_nettype wire

// >>> rtl/scs_route.sv
// smart-card serial channel: shared pin routing
// assumes the two-wire unit drives the pins itself when it owns them
`timescale 1ns/1ps
`default_nettype none
module scs_route import scs_pkg::*; (
  input wire logic [2:0] route_i,
  input wire logic od_i,
  input wire logic line_i,
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe_n_o,
  output logic rx_lvl_o,
  output logic two_wire_owns_o
);
  logic owns;

  // pins go to the two-wire unit when it is valid and selected
  assign owns = route_i[2] & (route_i[1] | route_i[0]);
  assign two_wire_owns_o = owns;
  assign pin_o = line_i;
  // push-pull drives unless the two-wire unit owns the pins; open drain also releases a high level
  assign pin_oe_n_o = owns | (od_i & line_i);
  assign rx_lvl_o = owns ? 1'b1 : pin_i;
endmodule
`default_nettype wire

// >>> shared/scs_pkg.sv
// smart-card serial channel: shared constants, types, helpers
// assumes a single 40 MHz clock and a classic Wishbone register bus
`default_nettype none
package scs_pkg;
  // register byte offsets
  localparam logic [7:0] ADR_MODE = 8'h00;
  localparam logic [7:0] ADR_CTL0 = 8'h04;
  localparam logic [7:0] ADR_CTL1 = 8'h08;
  localparam logic [7:0] ADR_BRG = 8'h0C;
  localparam logic [7:0] ADR_TXB = 8'h10;
  localparam logic [7:0] ADR_RXB = 8'h14;
  localparam logic [7:0] ADR_STAT = 8'h18;
  localparam logic [7:0] ADR_ROUTE = 8'h1C;
  // mode register fields
  localparam logic [2:0] MODE_8BIT = 3'h5;
  localparam int M_CKSEL = 3;
  localparam int M_STOP2 = 4;
  localparam int M_PEVEN = 5;
  localparam int M_PEN = 6;
  // control 0 fields
  localparam int C0_PRE_LO = 0;
  localparam int C0_OD = 2;
  localparam int C0_MSB = 7;
  // control 1 fields
  localparam int C1_TXEN = 0;
  localparam int C1_TXEMPTY = 1;
  localparam int C1_RXEN = 2;
  localparam int C1_RXFULL = 3;
  localparam int C1_TXCAUSE = 4;
  localparam int C1_INV = 6;
  localparam int C1_ERRSIG = 7;
  localparam logic [7:0] C1_WMASK = 8'hD5;
  // status fields, write one to clear
  localparam int S_TXIRQ = 0;
  localparam int S_RXIRQ = 1;
  localparam int S_CARDERR = 2;
  localparam int S_OVR = 3;
  localparam int S_FER = 4;
  localparam int S_PER = 5;
  localparam int S_ESUM = 6;
  // reset values
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [2:0] ROUTE_RST = 3'h0;
  // oversampling: sixteen ticks per bit
  localparam logic [3:0] OS_LAST = 4'hF;
  localparam logic [3:0] OS_MID = 4'h7;
  localparam logic [2:0] BITS_LAST = 3'h7;
  // prescaler terminal counts for f8 and f32, and the f1 and f8 select codes
  localparam logic [4:0] PRE8_END = 5'h07;
  localparam logic [4:0] PRE32_END = 5'h1F;
  localparam logic [1:0] PRE_F1 = 2'h0;
  localparam logic [1:0] PRE_F8 = 2'h1;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } scs_wb_req_type;

  typedef enum logic [5:0] {
    TX_IDLE = 6'b000001,
    TX_START = 6'b000010,
    TX_DATA = 6'b000100,
    TX_PAR = 6'b001000,
    TX_STOP = 6'b010000,
    TX_GUARD = 6'b100000
  } scs_tx_state_type;

  typedef enum logic [6:0] {
    RX_IDLE = 7'b0000001,
    RX_START = 7'b0000010,
    RX_DATA = 7'b0000100,
    RX_PAR = 7'b0001000,
    RX_STOP = 7'b0010000,
    RX_GAP = 7'b0100000,
    RX_ERR = 7'b1000000
  } scs_rx_state_type;

  // parity bit that makes data plus parity even or odd
  function automatic logic scs_par(input logic [7:0] d, input logic even);
    return (^d) ^ ~even;
  endfunction

  // optional data inversion at buffer write and read
  function automatic logic [7:0] scs_inv(input logic [7:0] d, input logic inv);
    return inv ? ~d : d;
  endfunction
endpackage
`default_nettype wire

// >>> sim/scs_card_model.sv
// card on the far side of the shared line: sends frames, reports errors
// assumes the bench resolves the pulled-up wire from all drivers
`timescale 1ns/1ps
`default_nettype none
module scs_card_model #(
  parameter int BIT_CLKS = 16
) (
  input wire logic clk_i,
  input wire logic line_i,
  input wire logic nack_en_i,
  output logic pull_low_o
);
  logic sending = 1'b0;
  // one frame: start, eight line bits first bit in d[0], parity, stop
  task automatic send(input logic [7:0] d, input logic par, input logic stop);
    logic [10:0] f;
    f = {stop, par, d, 1'b0};
    sending = 1'b1;
    for (int i = 0; i < 11; i++) begin
      @(posedge clk_i);
      pull_low_o <= ~f[i];
      repeat (BIT_CLKS - 1) @(posedge clk_i);
    end
    @(posedge clk_i);
    pull_low_o <= 1'b0;
    sending = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // error report: line held low across the guard time after a stop bit
  initial begin
    pull_low_o = 1'b0;
    forever begin
      @(negedge line_i);
      if (nack_en_i && !sending) begin
        repeat (11 * BIT_CLKS + 2) @(posedge clk_i);
        pull_low_o <= 1'b1;
        repeat (BIT_CLKS + 8) @(posedge clk_i);
        pull_low_o <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> sim/scs_channel_monitor.sv
// port checker for the smart-card serial channel
// assumes it is bound into every scs_channel instance
`timescale 1ns/1ps
`default_nettype none
module scs_channel_monitor import scs_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire scs_wb_req_type wb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic serial_in_pin_i,
  input wire logic serial_out_pin_o,
  input wire logic serial_out_pin_oe_n_o,
  input wire logic ext_baud_clock_pin_i,
  input wire logic port_route_sel_lo_o,
  input wire logic port_route_sel_hi_o,
  input wire logic two_wire_unit_valid_o,
  input wire logic two_wire_owns_o,
  input wire logic tx_int_o,
  input wire logic rx_int_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic req;
  // a bus request waiting for its answer
  assign req = wb_i.cyc && wb_i.stb && !wb_ack_o;
  ////////////////////////////////////////////////////////////////////////
  property p_ack_next;
    req |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack not a single pulse");
  property p_unmapped;
    req && !wb_i.we && wb_i.adr > ADR_ROUTE |=> wb_dat_o == 32'h00000000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_route_wr;
    req && wb_i.we && wb_i.sel[0] && wb_i.adr == ADR_ROUTE |=>
      {two_wire_unit_valid_o, port_route_sel_hi_o, port_route_sel_lo_o} == $past(wb_i.dat[2:0]);
  endproperty
  a_route_wr: assert property (p_route_wr) else $error("route outputs wrong");
  property p_owns;
    two_wire_owns_o == (two_wire_unit_valid_o && (port_route_sel_hi_o || port_route_sel_lo_o));
  endproperty
  a_owns: assert property (p_owns) else $error("pin owner wrong");
  property p_owns_float;
    two_wire_owns_o |-> serial_out_pin_oe_n_o;
  endproperty
  a_owns_float: assert property (p_owns_float) else $error("pin driven while routed away");
  property p_reset_quiet;
    $fell(rst_i) |-> serial_out_pin_o && !tx_int_o && !rx_int_o && !wb_ack_o;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
  property p_tx_pulse;
    tx_int_o |=> !tx_int_o;
  endproperty
  a_tx_pulse: assert property (p_tx_pulse) else $error("transmit request too long");
  property p_rx_pulse;
    rx_int_o |=> !rx_int_o;
  endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("receive request too long");
  property p_tx_done_high;
    tx_int_o |-> serial_out_pin_o && $past(serial_out_pin_o, 8);
  endproperty
  a_tx_done_high: assert property (p_tx_done_high) else $error("request before stop");
endmodule
bind scs_channel scs_channel_monitor u_mon (.clk_i, .rst_i, .wb_i, .wb_dat_o, .wb_ack_o,
  .serial_in_pin_i, .serial_out_pin_o, .serial_out_pin_oe_n_o, .ext_baud_clock_pin_i,
  .port_route_sel_lo_o, .port_route_sel_hi_o, .two_wire_unit_valid_o, .two_wire_owns_o,
  .tx_int_o, .rx_int_o);
`default_nettype wire

// >>> sim/smart_card_async_serial_test.sv
// bench for the smart-card serial channel: bus tasks, card model, frames
// assumes a 40 MHz clock and the bound port checker
`timescale 1ns/1ps
`default_nettype none
module smart_card_async_serial_test import scs_pkg::*;;
  localparam int BITC = 16;
  logic clk_i, rst_i, card_en, card_low, line, ack, pin_o, oe_n, tx_int, rx_int;
  logic sel_lo, sel_hi, valid, owns;
  logic [1:0] ext_cnt = 2'h0;
  logic [31:0] rdat;
  scs_wb_req_type wb;
  int fail_count = 0, n_compared = 0, rx_seen = 0, low_cnt = 0;
  int rate[4] = '{16, 256, 1536, 256};
  // pulled-up wire: low when the card or the enabled channel pulls it
  assign line = ~card_low & (oe_n | pin_o);
  scs_channel u_dut (.clk_i, .rst_i, .wb_i(wb), .wb_dat_o(rdat), .wb_ack_o(ack),
    .serial_in_pin_i(line), .serial_out_pin_o(pin_o), .serial_out_pin_oe_n_o(oe_n),
    .ext_baud_clock_pin_i(ext_cnt[1]), .port_route_sel_lo_o(sel_lo),
    .port_route_sel_hi_o(sel_hi), .two_wire_unit_valid_o(valid),
    .two_wire_owns_o(owns), .tx_int_o(tx_int), .rx_int_o(rx_int));
  scs_card_model #(.BIT_CLKS(BITC)) u_card (.clk_i, .line_i(line), .nack_en_i(card_en),
    .pull_low_o(card_low));
  // clock generator
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // external rate pin and event counters
  always @(posedge clk_i) begin
    ext_cnt <= ext_cnt + 2'h1;
    if (rx_int === 1'b1) rx_seen <= rx_seen + 1;
    if (pin_o === 1'b0) low_cnt <= low_cnt + 1;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic report_and_stop();
    $display("compared %0d, failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic hang();
    chk(16'h0, 16'h1);
    report_and_stop();
  endtask
  // one classic single bus cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] q);
    int n;
    @(posedge clk_i);
    wb <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: {24'h0, d}};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
      if (n > 20) hang();
    end while (ack !== 1'b1);
    q = rdat[7:0];
    wb <= '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(16'(q), 16'(e));
  endtask
  // wait: sel 0 line low, 1 transmit request, 2 line high
  task automatic wait_ev(input int sel, input int lim, output int cyc);
    for (cyc = 1; cyc <= lim; cyc++) begin
      @(posedge clk_i);
      if (sel == 0 ? line === 1'b0 : sel == 1 ? tx_int === 1'b1 : line === 1'b1) return;
    end
    hang();
  endtask
  // mid-bit samples of one frame leaving the channel
  task automatic frame(output logic [10:0] f);
    int c;
    wait_ev(0, 400, c);
    repeat (BITC / 2) @(posedge clk_i);
    for (int i = 0; i < 11; i++) begin
      f[i] = line;
      if (i < 10) repeat (BITC) @(posedge clk_i);
    end
  endtask
  function automatic logic [10:0] exp_frame(input logic [7:0] d, input logic inv);
    logic [7:0] l;
    l = {<<{d}};
    l = inv ? ~l : d;
    return {1'b1, ^l ^ inv, l, 1'b0};
  endfunction
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [10:0] f;
    logic [7:0] q;
    int c;
    rst_i = 1'b1;
    card_en = 1'b0;
    wb = '0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ADR_CTL1, 8'h02);
    rd(8'h20, 8'h00);
    for (int v = 0; v < 8; v++) begin
      wr(ADR_ROUTE, 8'(v));
      @(negedge clk_i);
      chk({owns, oe_n}, v[2] && v[1:0] != 0 ? 16'h3 : 16'h0);
    end
    wr(ADR_ROUTE, 8'h00);
    wr(ADR_CTL0, 8'h04);
    @(negedge clk_i);
    chk(16'(oe_n), 16'h1);
    wr(ADR_CTL0, 8'h00);
    wr(ADR_MODE, 8'h65);
    wr(ADR_CTL1, 8'h10);
    wr(ADR_TXB, 8'hA5);
    rd(ADR_CTL1, 8'h10);
    c = low_cnt;
    repeat (64) @(posedge clk_i);
    chk(16'(low_cnt - c), 16'h0);
    wr(ADR_CTL1, 8'h11);
    frame(f);
    chk(16'(f), 16'(exp_frame(8'hA5, 1'b0)));
    wait_ev(1, 40, c);
    rd(ADR_STAT, 8'h01);
    wr(ADR_MODE, 8'h45);
    wr(ADR_CTL0, 8'h80);
    wr(ADR_CTL1, 8'h51);
    wr(ADR_TXB, 8'hA5);
    frame(f);
    chk(16'(f), 16'(exp_frame(8'hA5, 1'b1)));
    wait_ev(1, 40, c);
    wr(ADR_CTL1, 8'h11);
    for (int k = 0; k < 4; k++) begin
      wr(ADR_MODE, k == 3 ? 8'h6D : 8'h65);
      wr(ADR_CTL0, 8'(k % 3));
      wr(ADR_BRG, 8'(k));
      wr(ADR_TXB, 8'h7F);
      wait_ev(0, 400, c);
      wait_ev(2, 2000, c);
      wait_ev(0, 20000, c);
      c = 0;
      while (line === 1'b0 && c < 9000) begin
        @(posedge clk_i);
        c++;
      end
      chk(16'(c), 16'(rate[k]));
      wait_ev(1, 9000, c);
    end
    wr(ADR_MODE, 8'h65);
    wr(ADR_CTL0, 8'h00);
    wr(ADR_BRG, 8'h00);
    wr(ADR_STAT, 8'h7F);
    wr(ADR_CTL1, 8'h91);
    card_en <= 1'b1;
    wr(ADR_TXB, 8'h3C);
    wait_ev(0, 400, c);
    wait_ev(1, 400, c);
    chk(16'(c >= 11 * BITC + 8 && c <= 11 * BITC + 10), 16'h1);
    rd(ADR_STAT, 8'h05);
    card_en <= 1'b0;
    wr(ADR_STAT, 8'h7F);
    wr(ADR_CTL1, 8'h00);
    u_card.send(8'h3C, 1'b0, 1'b1);
    chk(16'(rx_seen), 16'h0);
    wr(ADR_CTL1, 8'h04);
    u_card.send(8'h3C, 1'b0, 1'b1);
    chk(16'(rx_seen), 16'h1);
    rd(ADR_RXB, 8'h3C);
    u_card.send(8'h11, 1'b0, 1'b1);
    u_card.send(8'h22, 1'b0, 1'b1);
    chk(16'(rx_seen), 16'h2);
    rd(ADR_STAT, 8'h4A);
    rd(ADR_RXB, 8'h22);
    wr(ADR_CTL1, 8'h44);
    rd(ADR_RXB, 8'hDD);
    wr(ADR_STAT, 8'h7F);
    u_card.send(8'h33, 1'b0, 1'b0);
    repeat (12 * BITC) @(posedge clk_i);
    bus(1'b0, ADR_STAT, 8'h00, q);
    chk(16'(q & 8'h50), 16'h50);
    bus(1'b0, ADR_RXB, 8'h00, q);
    wr(ADR_STAT, 8'h7F);
    wr(ADR_CTL1, 8'h84);
    c = low_cnt;
    u_card.send(8'h3C, 1'b1, 1'b1);
    repeat (3 * BITC) @(posedge clk_i);
    chk(16'(low_cnt - c), 16'(BITC));
    bus(1'b0, ADR_STAT, 8'h00, q);
    chk(16'(q & 8'h60), 16'h60);
    report_and_stop();
  end
endmodule
`default_nettype wire
